// File: logic/iex_top.sv
// iex_top: interrupt factor expander, twelve ports of four factors
// assumes an APB master on pclk; pins arrive asynchronously,
// peripheral requests arrive on pclk
`timescale 1ns/100ps
module iex_top
  import iex_pkg::*;
#(
  parameter int PIN_FILTER = PIN_MIN_CYC
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external pins, active low
  input wire logic [15:0] external_irq_pin_n,
  input wire logic tdm_rx_enable_pin_n,
  input wire logic tdm_tx_enable_pin_n,
  input wire logic audio_rx_enable_pin_n,
  input wire logic audio_tx_enable_pin_n,
  input wire logic host_write_strobe_n,
  input wire logic host_read_strobe_n,
  // on-chip requests, active low
  input wire logic tdm_serial_port_rx_n,
  input wire logic tdm_serial_port_tx_n,
  input wire logic audio_serial_port_rx_n,
  input wire logic audio_serial_port_tx_n,
  input wire logic host_parallel_port_in_n,
  input wire logic host_parallel_port_out_n,
  input wire logic [1:0] timer_irq_n,
  input wire logic [7:0] pulse_timer_channel_n,
  input wire logic [3:0] card_irq_n,
  // to the core
  output logic [NUM_PORTS-1:0] core_irq_n,
  output logic [9:0] vector_addr,
  output logic vector_valid
);

  localparam int NPINS = 22;
  localparam int FW = $clog2(PIN_FILTER + 1);

  // both counts must fit their counters, or the filter and the mask window
  // would wrap and release requests too early
  if (PIN_FILTER < 1)
  begin : g_bad_filter
    $error("PIN_FILTER must be at least one");
  end
  if (HOLD_CYC < 1 || HOLD_CYC > 7)
  begin : g_bad_hold
    $error("HOLD_CYC must fit the three-bit mask window counter");
  end

  // ----------------------------------------------------------------
  // pin synchronisers and active-period filter
  // ----------------------------------------------------------------
  logic [NPINS-1:0] pin_raw;
  logic [NPINS-1:0] pin_meta_r;
  logic [NPINS-1:0] pin_sync_r;
  logic [NPINS-1:0] pin_clean_r;

  assign pin_raw = {host_read_strobe_n, host_write_strobe_n,
                    audio_tx_enable_pin_n, audio_rx_enable_pin_n,
                    tdm_tx_enable_pin_n, tdm_rx_enable_pin_n,
                    external_irq_pin_n};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_r <= {NPINS{1'b1}};
      pin_sync_r <= {NPINS{1'b1}};
    end
    else
    begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  // a level is taken only after it has stood PIN_FILTER system clocks,
  // so glitches shorter than that never reach the edge detectors
  genvar gp;
  generate
    for (gp = 0; gp < NPINS; gp++)
    begin : g_pin
      logic [FW-1:0] run_r;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          run_r <= '0;
          pin_clean_r[gp] <= 1'b1;
        end
        else if (pin_sync_r[gp] == pin_clean_r[gp])
          run_r <= '0;
        else if (run_r == FW'(PIN_FILTER - 1))
        begin
          run_r <= '0;
          pin_clean_r[gp] <= pin_sync_r[gp];
        end
        else
          run_r <= run_r + FW'(1);
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // factor routing
  // ----------------------------------------------------------------
  logic [FACTORS-1:0] factor_n [NUM_PORTS];

  always_comb
  begin
    for (int p = 0; p < 4; p++)
      factor_n[p] = pin_clean_r[4*p +: 4];
    factor_n[4] = {card_irq_n[0], pulse_timer_channel_n[0], pin_clean_r[16],
                   tdm_serial_port_rx_n};
    factor_n[5] = {card_irq_n[1], pulse_timer_channel_n[1], pin_clean_r[17],
                   tdm_serial_port_tx_n};
    factor_n[6] = {card_irq_n[2], pulse_timer_channel_n[2], pin_clean_r[18],
                   audio_serial_port_rx_n};
    factor_n[7] = {card_irq_n[3], pulse_timer_channel_n[3], pin_clean_r[19],
                   audio_serial_port_tx_n};
    factor_n[8] = {1'b1, pulse_timer_channel_n[4], pin_clean_r[20],
                   host_parallel_port_in_n};
    factor_n[9] = {1'b1, pulse_timer_channel_n[5], pin_clean_r[21],
                   host_parallel_port_out_n};
    factor_n[10] = {1'b1, pulse_timer_channel_n[6], timer_irq_n[1], timer_irq_n[0]};
    factor_n[11] = {1'b1, pulse_timer_channel_n[7], timer_irq_n[0], timer_irq_n[1]};
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [13:0] reg_idx;
  logic hit;
  logic [3:0] port_sel;
  logic access;
  logic setup;

  assign reg_idx = paddr[APB_AW-1:2];
  assign hit = (paddr[1:0] == 2'h0) && (reg_idx >= ICR_IDX_BASE) &&
               (reg_idx <= ICR_IDX_LAST);
  assign port_sel = 4'(reg_idx - ICR_IDX_BASE);
  assign setup = psel & ~penable;
  // pready is raised from the setup cycle, so every access is one cycle
  assign access = psel & penable & pready;

  // ----------------------------------------------------------------
  // ports
  // ----------------------------------------------------------------
  logic [NUM_PORTS-1:0] wr_en;
  logic [NUM_PORTS-1:0] rd_en;
  logic force_mask;
  iex_ctrl_s wr_ctrl;
  iex_ctrl_s ctrl [NUM_PORTS];
  iex_port_stat_s stat [NUM_PORTS];
  logic [NUM_PORTS-1:0] irq_n;

  assign wr_ctrl.mode = pwdata[MODE_BIT];
  assign wr_ctrl.mask = pwdata[MASK_LSB +: FACTORS];

  genvar gq;
  generate
    for (gq = 0; gq < NUM_PORTS; gq++)
    begin : g_port
      assign wr_en[gq] = access & hit & pwrite & (port_sel == 4'(gq));
      assign rd_en[gq] = access & hit & ~pwrite & (port_sel == 4'(gq));
      assign irq_n[gq] = stat[gq].irq_n;
      iex_port u_port (
        .pclk(pclk),
        .presetn(presetn),
        .factor_n(factor_n[gq]),
        .wr_en(wr_en[gq]),
        .wr_ctrl(wr_ctrl),
        .rd_en(rd_en[gq]),
        .force_mask(force_mask),
        .ctrl(ctrl[gq]),
        .stat(stat[gq])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // post-read mask window
  // ----------------------------------------------------------------
  logic [2:0] hold_r;

  // read edge itself masks, then the counter covers the remaining cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_r <= '0;
    else if (|rd_en)
      hold_r <= 3'(HOLD_CYC - 1);
    else if (hold_r != 3'h0)
      hold_r <= hold_r - 3'h1;
  end

  assign force_mask = (|rd_en) | (hold_r != 3'h0);

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  logic [31:0] rdata_nxt;

  // reserved bits 15:9 read as zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (hit && !pwrite)
    begin
      rdata_nxt[MODE_BIT] = ctrl[port_sel].mode;
      rdata_nxt[MASK_LSB +: FACTORS] = ctrl[port_sel].mask;
      rdata_nxt[STAMP_LSB +: FACTORS] = stat[port_sel].stamp;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= setup ? rdata_nxt : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // core outputs and vector
  // ----------------------------------------------------------------
  logic [9:0] vec_nxt;
  logic vec_hit;

  // lowest-numbered active port wins the vector
  always_comb
  begin
    vec_nxt = VEC_RESET;
    vec_hit = 1'b0;
    for (int p = NUM_PORTS - 1; p >= 0; p--)
    begin
      if (!irq_n[p])
      begin
        vec_nxt = VEC_PORT_BASE + 10'(p) * VEC_PORT_STEP;
        vec_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vector_addr <= VEC_RESET;
      vector_valid <= 1'b0;
    end
    else
    begin
      vector_addr <= vec_nxt;
      vector_valid <= vec_hit;
    end
  end

  assign core_irq_n = irq_n;

endmodule // iex_top

// File: pkg/iex_pkg.sv
// iex_pkg: constants and carriers of the interrupt factor expander
// assumes a 125 MHz pclk and an APB register bus with 32-bit data
package iex_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 12;
  localparam int FACTORS = 4;
  localparam int APB_AW = 16;
  localparam logic [13:0] ICR_IDX_BASE = 14'h3880;
  localparam logic [13:0] ICR_IDX_LAST = 14'h388B;
  localparam int MODE_BIT = 8;
  localparam int MASK_LSB = 4;
  localparam int STAMP_LSB = 0;
  localparam logic [15:0] ICR_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // vector table and timing
  // ----------------------------------------------------------------
  localparam logic [9:0] VEC_RESET = 10'h200;
  localparam int VEC_RESET_WORDS = 16;
  localparam logic [9:0] VEC_PORT_BASE = 10'h210;
  localparam logic [9:0] VEC_PORT_STEP = 10'h004;
  localparam int HOLD_CYC = 4;
  localparam int CLK_MHZ = 125;
  localparam int PIN_MIN_NS = 16;
  localparam int PIN_MIN_CYC = (PIN_MIN_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mode;
    logic [FACTORS-1:0] mask;
  } iex_ctrl_s;

  typedef struct packed {
    logic [FACTORS-1:0] stamp;
    logic irq_n;
  } iex_port_stat_s;

endpackage

// File: logic/iex_port.sv
// iex_port: one core interrupt port with its control register
// assumes factor inputs are already on pclk, active low
`timescale 1ns/100ps
module iex_port
  import iex_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // factor requests
  input wire logic [FACTORS-1:0] factor_n,
  // register access
  input wire logic wr_en,
  input wire iex_ctrl_s wr_ctrl,
  input wire logic rd_en,
  input wire logic force_mask,
  // state
  output iex_ctrl_s ctrl,
  output iex_port_stat_s stat
);

  logic mode_r;
  logic [FACTORS-1:0] mask_r;
  logic [FACTORS-1:0] stamp_r;
  logic [FACTORS-1:0] stamp_nxt;
  logic [FACTORS-1:0] prev_n_r;
  logic [FACTORS-1:0] fall;
  logic irq_n_r;
  logic level;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= ICR_RESET[MODE_BIT];
      mask_r <= ICR_RESET[MASK_LSB +: FACTORS];
    end
    else if (wr_en)
    begin
      mode_r <= wr_ctrl.mode;
      mask_r <= wr_ctrl.mask;
    end
  end

  // ----------------------------------------------------------------
  // edge detect and stamps
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_n_r <= {FACTORS{1'b1}};
    else
      prev_n_r <= factor_n;
  end

  assign fall = prev_n_r & ~factor_n;

  // set is applied after clear so a same-cycle edge survives the read
  always_comb
  begin
    stamp_nxt = rd_en ? '0 : stamp_r;
    if (mode_r)
      stamp_nxt = stamp_nxt | (fall & mask_r);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stamp_r <= ICR_RESET[STAMP_LSB +: FACTORS];
    else
      stamp_r <= stamp_nxt;
  end

  // ----------------------------------------------------------------
  // output to the core
  // ----------------------------------------------------------------
  // stamps stay until read, so the output stays low meanwhile except in the forced mask window after any port's read
  assign level = mode_r ? (|stamp_r) : (|(~factor_n & mask_r));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_n_r <= 1'b1;
    else
      irq_n_r <= force_mask | ~level;
  end

  assign ctrl.mode = mode_r;
  assign ctrl.mask = mask_r;
  assign stat.stamp = stamp_r;
  assign stat.irq_n = irq_n_r;

endmodule // iex_port

// File: dv/iex_asserts.sv
// iex_asserts: timing checks on the expander's top-level ports
// assumes it is bound to iex_top and that pclk is the only clock
`timescale 1ns/100ps
module iex_asserts
  import iex_pkg::*;
#(
  parameter int PIN_FILTER = 2
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // factors
  input wire logic [15:0] external_irq_pin_n,
  input wire logic tdm_serial_port_rx_n,
  input wire logic [7:0] pulse_timer_channel_n,
  // core side
  input wire logic [NUM_PORTS-1:0] core_irq_n,
  input wire logic [9:0] vector_addr,
  input wire logic vector_valid
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic done;
  logic rd_done;
  logic [4:0] sh0_r;
  logic [4:0] sh4_r;
  logic [2:0] win_r;
  logic [3:0] low_r;
  assign done = psel && penable && pready && !pslverr;
  assign rd_done = done && !pwrite;
  // shadows of mode and mask for ports 0 and 4 only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh0_r <= 5'h00;
      sh4_r <= 5'h00;
    end
    else if (done && pwrite && paddr == 16'hE200)
      sh0_r <= pwdata[8:4];
    else if (done && pwrite && paddr == 16'hE210)
      sh4_r <= pwdata[8:4];
  end
  // kept longer than the forced mask so no check straddles it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      win_r <= 3'h0;
    else if (rd_done)
      win_r <= 3'h6;
    else if (win_r != 3'h0)
      win_r <= win_r - 3'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_r <= 4'h0;
    else if (external_irq_pin_n[3])
      low_r <= 4'h0;
    else if (low_r != 4'hF)
      low_r <= low_r + 4'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_reset_idle: assert property ($rose(presetn) |-> core_irq_n == '1)
    else $error("core request active after reset");
  a_read_window: assert property (rd_done |-> ##1 (core_irq_n == '1) [*4])
    else $error("core request seen inside read window");
  a_masked_high: assert property (sh4_r == 5'h00 && $past(sh4_r) == 5'h00 |-> core_irq_n[4])
    else $error("masked port drives a request");
  a_mask_or: assert property (!sh4_r[4] && sh4_r[3:0] == 4'h5 && $past(sh4_r) == sh4_r
    && win_r == 3'h0 |-> core_irq_n[4] == $past(tdm_serial_port_rx_n & pulse_timer_channel_n[0]))
    else $error("mask mode output does not follow its factor");
  a_stamp_set: assert property ((sh4_r[4] && sh4_r[0] && $fell(tdm_serial_port_rx_n)
    && win_r == 3'h0 && !done) ##1 !rd_done |=> !core_irq_n[4])
    else $error("stamp mode edge gave no request");
  a_stamp_hold: assert property (sh4_r[4] && $past(sh4_r[4]) && !core_irq_n[4]
    && win_r == 3'h0 && !done |=> !core_irq_n[4])
    else $error("stamp request dropped without a read");
  a_vector_idle: assert property (!vector_valid |-> vector_addr == VEC_RESET)
    else $error("idle vector is not the reset vector");
  a_vector_port: assert property (vector_valid |-> vector_addr[1:0] == 2'h0
    && vector_addr >= VEC_PORT_BASE && vector_addr <= 10'h23C)
    else $error("vector outside the port table");
  a_pin_fall: assert property (sh0_r[4] && sh0_r[3] && low_r == 4'(PIN_FILTER + 2)
    |-> ##[1:10] !core_irq_n[0])
    else $error("held pin edge gave no request");
endmodule // iex_asserts

// File: dv/iex_src_model.sv
// iex_src_model: external interrupt sources behind the sixteen pins
// assumes requests arrive as one-cycle pulses on pclk
`timescale 1ns/100ps
module iex_src_model
(
  // clock
  input wire logic pclk,
  // requests and low time in cycles
  input wire logic [15:0] fire,
  input wire logic [7:0] hold,
  // pins, pulled up while idle
  output logic [15:0] pin_n
);
  // ----------------------------------------------------------------
  // pulse shaping
  // ----------------------------------------------------------------
  int cnt [16] = '{default: 0};
  // requests during a pulse are dropped, so high always lasts at least one cycle longer than low
  always @(posedge pclk)
    for (int i = 0; i < 16; i++)
      if (cnt[i] != 0)
        cnt[i] <= cnt[i] - 1;
      else if (fire[i])
        cnt[i] <= 2 * hold;
  always_comb
    for (int i = 0; i < 16; i++)
      pin_n[i] = !(cnt[i] > hold);
endmodule // iex_src_model

// File: dv/iex_top_tb.sv
// iex_top_tb: self-checking bench for the interrupt factor expander
// assumes the source model drives the sixteen external_irq_pin_n pins and the bench the rest
`timescale 1ns/100ps
module iex_top_tb
  import iex_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] f0_n = 8'hFF;
  logic [5:0] f1_n = 6'h3F;
  logic [7:0] pt_n = 8'hFF;
  logic [3:0] card_n = 4'hF;
  logic [15:0] fire = 16'h0000;
  logic [15:0] pin_n;
  logic [NUM_PORTS-1:0] core_irq_n;
  logic [9:0] vector_addr;
  logic vector_valid;
  logic [31:0] q;
  logic qe;
  int err_count = 0;
  int comparisons = 0;
  always #4 pclk = ~pclk;
  iex_src_model iex_src_model_inst (.pclk, .fire, .hold(8'h05), .pin_n);
  iex_top #(.PIN_FILTER(2)) iex_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .external_irq_pin_n(pin_n),
    .tdm_rx_enable_pin_n(f1_n[0]), .tdm_tx_enable_pin_n(f1_n[1]),
    .audio_rx_enable_pin_n(f1_n[2]), .audio_tx_enable_pin_n(f1_n[3]),
    .host_write_strobe_n(f1_n[4]), .host_read_strobe_n(f1_n[5]),
    .tdm_serial_port_rx_n(f0_n[0]), .tdm_serial_port_tx_n(f0_n[1]),
    .audio_serial_port_rx_n(f0_n[2]), .audio_serial_port_tx_n(f0_n[3]),
    .host_parallel_port_in_n(f0_n[4]), .host_parallel_port_out_n(f0_n[5]),
    .timer_irq_n(f0_n[7:6]), .pulse_timer_channel_n(pt_n), .card_irq_n(card_n),
    .core_irq_n, .vector_addr, .vector_valid);
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic logic [15:0] addr(input int p);
    return 16'hE200 + 16'(4 * p);
  endfunction
  // one idle edge first, so psel never changes twice in one step
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
    input logic fall);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (fall)
      card_n[0] <= 1'b0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
    begin
      err_count++;
      end_sim();
    end
    q = prdata;
    qe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_low(input int p);
    int n;
    n = 0;
    while (core_irq_n[p] !== 1'b0 && n < 30)
    begin
      @(posedge pclk);
      n++;
    end
    chk(32'(core_irq_n[p]), 32'h0);
    if (n == 30)
      end_sim();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(32'(core_irq_n), 32'h0000_0FFF);
    chk(32'({vector_valid, vector_addr}), 32'h0000_0200);
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      apb(1'b0, addr(p), 32'h0, 1'b0);
      chk(q, 32'(ICR_RESET));
      apb(1'b1, addr(p), 32'({p[0], 4'(p)}) << 4, 1'b0);
      apb(1'b0, addr(p), 32'h0, 1'b0);
      chk(q, 32'({p[0], 4'(p)}) << 4);
      apb(1'b1, addr(p), 32'h0, 1'b0);
    end
    apb(1'b0, 16'hE230, 32'h0, 1'b0);
    chk(32'(qe), 32'h1);
    chk(q, 32'h0000_0000);
  endtask
  task automatic t_mask();
    for (int p = 4; p < NUM_PORTS; p++)
    begin
      apb(1'b1, addr(p), 32'h0000_0050, 1'b0);
      f0_n[p-4] <= 1'b0;
      cyc(3);
      chk(32'(core_irq_n[p]), 32'h0);
      f0_n[p-4] <= 1'b1;
      pt_n[p-4] <= 1'b0;
      cyc(3);
      chk(32'(core_irq_n[p]), 32'h0);
      pt_n[p-4] <= 1'b1;
      cyc(3);
      chk(32'(core_irq_n[p]), 32'h1);
      apb(1'b1, addr(p), 32'h0, 1'b0);
      f0_n[p-4] <= 1'b0;
      cyc(3);
      chk(32'(core_irq_n[p]), 32'h1);
      f0_n[p-4] <= 1'b1;
    end
  endtask
  task automatic t_stamp();
    apb(1'b1, addr(4), 32'h0000_01F0, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      f0_n[0] <= 1'b0;
      cyc(1);
      f0_n[0] <= 1'b1;
      wait_low(4);
      cyc(3);
    end
    chk(32'(vector_addr), 32'h0000_0220);
    chk(32'(vector_valid), 32'h1);
    chk(32'(core_irq_n[4]), 32'h0);
    apb(1'b0, addr(4), 32'h0, 1'b0);
    chk(q, 32'h0000_01F1);
    cyc(2);
    chk(32'(core_irq_n), 32'h0000_0FFF);
    cyc(6);
    chk(32'(core_irq_n[4]), 32'h1);
    apb(1'b0, addr(4), 32'h0, 1'b0);
    chk(q, 32'h0000_01F0);
  endtask
  task automatic t_beat();
    apb(1'b0, addr(4), 32'h0, 1'b1);
    card_n[0] <= 1'b1;
    wait_low(4);
    apb(1'b0, addr(4), 32'h0, 1'b0);
    chk(q, 32'h0000_01F8);
  endtask
  task automatic t_pin();
    apb(1'b1, addr(0), 32'h0000_01F0, 1'b0);
    fire <= 16'h0008;
    cyc(1);
    fire <= 16'h0000;
    wait_low(0);
    apb(1'b0, addr(0), 32'h0, 1'b0);
    chk(q, 32'h0000_01F8);
    cyc(12);
    chk(32'(core_irq_n[0]), 32'h1);
  endtask
  initial
  begin
    cyc(6);
    presetn <= 1'b1;
    t_reset();
    t_mask();
    t_stamp();
    t_beat();
    t_pin();
    end_sim();
  end
endmodule // iex_top_tb

bind iex_top iex_asserts #(.PIN_FILTER(PIN_FILTER)) iex_asserts_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .external_irq_pin_n,
  .tdm_serial_port_rx_n, .pulse_timer_channel_n, .core_irq_n, .vector_addr, .vector_valid);
